// ==== hdl/rspt_top.sv ====
// Reset source combiner, power-up timer and reset cause register with AHB-Lite access
//
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module rspt_top #(
  parameter int unsigned TICK_CYCLES = rspt_pkg::RC_TICK_CYCLES,
  parameter int unsigned POWER_UP_TIMER_TICKS  = rspt_pkg::POWER_UP_TIMER_COUNT
) (
  // Clock and power-on reset
  input  wire logic                                   hclk,
  input  wire logic                                   hresetn,
  // AHB-Lite slave
  input  wire logic                                   hsel,
  input  wire logic [31:0]                            haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [31:0]                            hwdata,
  input  wire logic                                   hready,
  output logic [31:0]                                 hrdata,
  output logic                                        hreadyout,
  output logic                                        hresp,
  // External reset pin
  input  wire logic                                   external_reset_pin_in,
  output logic                                        external_reset_pin_out,
  output logic                                        external_reset_pin_oe,
  // Supply monitor
  input  wire rspt_pkg::rspt_supply_t                 supply,
  // Configuration words and shadows
  input  wire rspt_pkg::rspt_cfg_pair_t [rspt_pkg::CFG_REGS-1:0] config_pairs,
  // Core reset
  output logic                                        core_reset_n
);

  // Bus state
  logic                        dp_valid_q;
  logic                        dp_write_q;
  logic [7:0]                  dp_addr_q;
  logic [31:0]                 rdata_q;
  logic                        wr_reset_control_register;
  logic                        wr_ctrl;

  // Reset cause flags and control
  logic                        brownout_flag_q;
  logic                        poweron_flag_q;
  logic                        reset_inst_flag_q;
  logic                        config_mismatch_flag_q;
  logic                        prio_en_q;
  logic [rspt_pkg::FILT_BITS-1:0] filt_len_q;

  // Sources
  logic                        pin_low;
  logic                        brownout_active;
  logic [rspt_pkg::CFG_REGS-1:0] pair_bad;
  logic                        mismatch;

  // Power-up timer
  rspt_pkg::rspt_pt_state_t    pt_state_q;
  logic [rspt_pkg::TICK_BITS-1:0] tick_cnt_q;
  logic                        tick;
  logic [rspt_pkg::POWER_UP_TIMER_BITS-1:0] power_up_timer_q;
  logic                        pt_last;
  logic                        core_reset_n_q;

  // Register views
  logic [31:0]                 reset_control_register_view;
  logic [31:0]                 status_view;

  // Read mux shared by the address phase decode
  function automatic logic [31:0] rspt_read(input logic [7:0] ofs,
                                            input logic [31:0] reset_control_register_v,
                                            input logic [31:0] stat_v,
                                            input logic [rspt_pkg::FILT_BITS-1:0] flen);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (ofs)
      rspt_pkg::OFS_RESET_CTRL: r = reset_control_register_v;
      rspt_pkg::OFS_STATUS:     r = stat_v;
      rspt_pkg::OFS_CONTROL:    r = {29'h0000_0000, flen};
      default:                  r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // Config pair check, one per register
  function automatic logic rspt_pair_bad(input rspt_pkg::rspt_cfg_pair_t p);
    return p.value != ~p.shadow;
  endfunction

  // External pin filter
  rspt_pin_filter u_pin_filter (
    .clk      (hclk),
    .rst_n    (hresetn),
    .pin_in   (external_reset_pin_in),
    .filt_len (filt_len_q),
    .pin_low  (pin_low)
  );

  // The pin is input only; internal resets never pull it low
  assign external_reset_pin_out = 1'b1;
  assign external_reset_pin_oe  = 1'b0;

  // Brown-out only exists with the regulator enabled
  assign brownout_active = supply.regulator_enable_pin && !supply.regulator_ok;

  // Continuous compare of every configuration pair
  genvar gi;
  generate
    for (gi = 0; gi < rspt_pkg::CFG_REGS; gi++) begin : g_cfg
      assign pair_bad[gi] = rspt_pair_bad(config_pairs[gi]);
    end
  endgenerate
  assign mismatch = |pair_bad;

  // RC oscillator tick derived from the bus clock
  assign tick = (tick_cnt_q == rspt_pkg::TICK_BITS'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= '0;
    end else if (tick || pt_state_q != rspt_pkg::RSPT_PT_COUNT) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  assign pt_last = tick && (power_up_timer_q == rspt_pkg::POWER_UP_TIMER_BITS'(POWER_UP_TIMER_TICKS - 1));

  // Power-up timer sequencing; it starts on release of power-on reset and has no bypass
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pt_state_q <= rspt_pkg::RSPT_PT_COUNT;
    end else begin
      unique case (pt_state_q)
        rspt_pkg::RSPT_PT_HOLD: begin
          if (!brownout_active) begin
            pt_state_q <= rspt_pkg::RSPT_PT_COUNT;
          end
        end
        rspt_pkg::RSPT_PT_COUNT: begin
          if (brownout_active) begin
            pt_state_q <= rspt_pkg::RSPT_PT_HOLD;
          end else if (pt_last) begin
            pt_state_q <= rspt_pkg::RSPT_PT_DONE;
          end
        end
        rspt_pkg::RSPT_PT_DONE: begin
          if (brownout_active) begin
            pt_state_q <= rspt_pkg::RSPT_PT_HOLD;
          end
        end
        default: pt_state_q <= rspt_pkg::RSPT_PT_HOLD;
      endcase
    end
  end

  // Eleven-bit count of RC ticks, reinitialised whenever not counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_up_timer_q <= '0;
    end else if (pt_state_q != rspt_pkg::RSPT_PT_COUNT || brownout_active) begin
      power_up_timer_q <= '0;
    end else if (tick) begin
      power_up_timer_q <= power_up_timer_q + 1'b1;
    end
  end

  // One combined internal reset; released only when every source is clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_reset_n_q <= 1'b0;
    end else begin
      core_reset_n_q <= !(pin_low || brownout_active || mismatch
                          || pt_state_q != rspt_pkg::RSPT_PT_DONE);
    end
  end
  assign core_reset_n = core_reset_n_q;

  // AHB-Lite address phase capture; zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q  <= 8'h00;
    end else if (hready) begin
      // Only the low 256 bytes are mapped; a write above them must not alias a register
      dp_valid_q <= hsel && htrans[1] && haddr[31:8] == 24'h00_0000;
      dp_write_q <= hwrite;
      dp_addr_q  <= haddr[7:0];
    end
  end

  // Read data taken during the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite && haddr[31:8] == 24'h00_0000) begin
      rdata_q <= rspt_read(haddr[7:0], reset_control_register_view, status_view, filt_len_q);
    end else if (hready) begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_reset_control_register   = dp_valid_q && dp_write_q && dp_addr_q == rspt_pkg::OFS_RESET_CTRL;
  assign wr_ctrl   = dp_valid_q && dp_write_q && dp_addr_q == rspt_pkg::OFS_CONTROL;

  // Power-on flag: power-on reset or a software write of zero clears, only software sets
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poweron_flag_q <= rspt_pkg::RST_POWERON;
    end else if (wr_reset_control_register) begin
      poweron_flag_q <= hwdata[rspt_pkg::BIT_POWERON];
    end
  end

  // Brown-out flag: the hardware clear wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brownout_flag_q <= rspt_pkg::RST_BROWNOUT;
    end else if (brownout_active) begin
      brownout_flag_q <= 1'b0;
    end else if (wr_reset_control_register) begin
      brownout_flag_q <= hwdata[rspt_pkg::BIT_BROWNOUT];
    end
  end

  // Mismatch flag: power-on reset sets it, a mismatch clears it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_mismatch_flag_q <= rspt_pkg::RST_MISMATCH;
    end else if (mismatch) begin
      config_mismatch_flag_q <= 1'b0;
    end else if (wr_reset_control_register) begin
      config_mismatch_flag_q <= hwdata[rspt_pkg::BIT_MISMATCH];
    end
  end

  // Software-only bits of the reset control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_inst_flag_q <= rspt_pkg::RST_RESET_INST;
      prio_en_q         <= rspt_pkg::RST_PRIO_EN;
    end else if (wr_reset_control_register) begin
      reset_inst_flag_q <= hwdata[rspt_pkg::BIT_RESET_INST];
      prio_en_q         <= hwdata[rspt_pkg::BIT_PRIO_EN];
    end
  end

  // Filter length; zero makes the pin act after the synchroniser alone
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_len_q <= rspt_pkg::FILT_LEN_RESET;
    end else if (wr_ctrl) begin
      filt_len_q <= hwdata[rspt_pkg::FILT_BITS-1:0];
    end
  end

  // Register views; cause flags in the low six bits
  always_comb begin
    reset_control_register_view = 32'h0000_0000;
    reset_control_register_view[rspt_pkg::BIT_BROWNOUT]   = brownout_flag_q;
    reset_control_register_view[rspt_pkg::BIT_POWERON]    = poweron_flag_q;
    reset_control_register_view[rspt_pkg::BIT_PWRDOWN]    = rspt_pkg::FIXED_PWRDOWN;
    reset_control_register_view[rspt_pkg::BIT_TIMEOUT]    = rspt_pkg::FIXED_TIMEOUT;
    reset_control_register_view[rspt_pkg::BIT_RESET_INST] = reset_inst_flag_q;
    reset_control_register_view[rspt_pkg::BIT_MISMATCH]   = config_mismatch_flag_q;
    reset_control_register_view[rspt_pkg::BIT_PRIO_EN]    = prio_en_q;
  end

  always_comb begin
    status_view = 32'h0000_0000;
    status_view[rspt_pkg::ST_CORE_RST] = !core_reset_n_q;
    status_view[rspt_pkg::ST_PIN_LOW]  = pin_low;
    status_view[rspt_pkg::ST_BROWNOUT] = brownout_active;
    status_view[rspt_pkg::ST_MISMATCH] = mismatch;
    status_view[rspt_pkg::ST_POWER_UP_TIMER_RUN] = pt_state_q == rspt_pkg::RSPT_PT_COUNT;
    status_view[rspt_pkg::ST_POWER_UP_TIMER_LSB +: rspt_pkg::POWER_UP_TIMER_BITS] = power_up_timer_q;
  end

  // Helper: marks the first cycle after power-on reset release
  logic first_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pin_never_driven: assert property (!external_reset_pin_oe)
    else $error("reset pin output enable asserted");
  a_por_flag_cleared: assert property (first_q |-> !poweron_flag_q && !brownout_flag_q)
    else $error("power-on flag not clear after power-on reset");
  a_por_sw_only: assert property ($rose(poweron_flag_q) |-> $past(wr_reset_control_register) && $past(hwdata[1]))
    else $error("power-on flag set without software write");
  a_bor_flag_clear: assert property (brownout_active |=> !brownout_flag_q)
    else $error("brown-out flag not cleared by brown-out");
  a_bor_disabled: assert property (!supply.regulator_enable_pin && !pin_low && !mismatch
                                   && pt_state_q == rspt_pkg::RSPT_PT_DONE |=> core_reset_n)
    else $error("regulator state raised reset while regulator disabled");
  a_cm_flag_reset: assert property (mismatch |=> !config_mismatch_flag_q && !core_reset_n)
    else $error("mismatch did not clear flag or hold reset");
  a_pin_holds_reset: assert property (pin_low |=> !core_reset_n)
    else $error("pin low did not hold core reset");
  a_power_up_timer_holds: assert property (pt_state_q != rspt_pkg::RSPT_PT_DONE |=> !core_reset_n)
    else $error("core released while power-up timer not done");
  a_power_up_timer_restart: assert property (brownout_active && pt_state_q == rspt_pkg::RSPT_PT_COUNT
                                   |=> pt_state_q == rspt_pkg::RSPT_PT_HOLD && power_up_timer_q == '0)
    else $error("brown-out did not reinitialise power-up timer");
  a_bor_then_timer: assert property (pt_state_q == rspt_pkg::RSPT_PT_HOLD && !brownout_active
                                     |=> pt_state_q == rspt_pkg::RSPT_PT_COUNT ##1 !core_reset_n)
    else $error("brown-out end not followed by timer interval");
  a_fast_release: assert property ($fell(pin_low) && pt_state_q == rspt_pkg::RSPT_PT_DONE
                                   && !brownout_active && !mismatch |=> core_reset_n)
    else $error("release after expired timer was delayed");

  // Combiner, filter and timer start; a missing source in the OR would slip past the checks above
  a_core_combine: assert property (core_reset_n |-> $past(!pin_low && !brownout_active && !mismatch
                                   && pt_state_q == rspt_pkg::RSPT_PT_DONE))
    else $error("core released while a reset source was active");
  a_pin_filtered: assert property ($rose(pin_low) |-> !$past(external_reset_pin_in, 3))
    else $error("pin reset raised without a synchronised low sample");
  a_timer_starts: assert property (first_q |-> pt_state_q == rspt_pkg::RSPT_PT_COUNT
                                   && power_up_timer_q == '0)
    else $error("power-up timer not counting from zero after power-on");
  a_timer_hold_zero: assert property (pt_state_q == rspt_pkg::RSPT_PT_HOLD
                                      |-> power_up_timer_q == '0)
    else $error("power-up timer not held at zero during brown-out");
  a_cm_release: assert property ($fell(mismatch) && !pin_low && !brownout_active
                                 && pt_state_q == rspt_pkg::RSPT_PT_DONE |=> core_reset_n)
    else $error("mismatch end did not release core at once");

  c_core_release:  cover property ($rose(core_reset_n));
  c_bor_restart:   cover property (pt_state_q == rspt_pkg::RSPT_PT_COUNT ##1 pt_state_q == rspt_pkg::RSPT_PT_HOLD);
  c_mismatch:      cover property ($rose(mismatch));
  c_pin_release:   cover property ($fell(pin_low) ##1 core_reset_n);
  c_timer_done:    cover property (pt_state_q == rspt_pkg::RSPT_PT_COUNT ##1 pt_state_q == rspt_pkg::RSPT_PT_DONE);

endmodule

// ==== hdl/rspt_pkg.sv ====
// Package: constants and carrier types for the reset source and power-up timer block
// Summary of operation
// - Low external reset pin holds device in reset
// - Short low glitches on pin are ignored
// - Device never drives the external reset pin
// - Power-on reset initialises all logic
// - Power-on flag cleared by power-on reset or a software write of zero
// - Only software writing one sets power-on flag
// - Regulator undervoltage raises brown-out reset when enabled
// - Brown-out holds reset until regulator output sufficient
// - One power-up timer interval follows each brown-out
// - Brown-out during timer run restarts the timer
// - Brown-out flag cleared by brown-out or power-on
// - Regulator disabled: no brown-out, power-on still clears
// - Config pairs compared continuously; mismatch forces reset
// - Mismatch flag cleared by mismatch events or a software write of zero
// - Power-up timer always enabled, never bypassed
// - Timer: 11-bit count of 32 us ticks
// - Reset held while power-up timer counts
// - Timer starts after power-on pulse clears
// - Pin release after timer expiry releases immediately
// - Cause flags sit in low six bits
package rspt_pkg;

  // Clock and timer timing
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned RC_PERIOD_NS   = 32000;
  localparam int unsigned RC_TICK_CYCLES = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POWER_UP_TIMER_BITS      = 11;
  localparam int unsigned POWER_UP_TIMER_COUNT     = 2048;
  localparam int unsigned TICK_BITS      = 16;

  // Pin filter
  localparam int unsigned FILT_BITS      = 3;
  localparam logic [2:0]  FILT_LEN_RESET = 3'h4;

  // Configuration pairs under watch
  localparam int unsigned CFG_REGS       = 4;
  localparam int unsigned CFG_WIDTH      = 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_RESET_CTRL = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_CONTROL    = 8'h08;

  // Reset control register bit positions
  localparam int unsigned BIT_BROWNOUT   = 0;
  localparam int unsigned BIT_POWERON    = 1;
  localparam int unsigned BIT_PWRDOWN    = 2;
  localparam int unsigned BIT_TIMEOUT    = 3;
  localparam int unsigned BIT_RESET_INST = 4;
  localparam int unsigned BIT_MISMATCH   = 5;
  localparam int unsigned BIT_PRIO_EN    = 7;

  // Values after power-on reset
  localparam logic RST_BROWNOUT   = 1'b0;
  localparam logic RST_POWERON    = 1'b0;
  localparam logic RST_RESET_INST = 1'b1;
  localparam logic RST_MISMATCH   = 1'b1;
  localparam logic RST_PRIO_EN    = 1'b0;
  localparam logic FIXED_PWRDOWN  = 1'b1;
  localparam logic FIXED_TIMEOUT  = 1'b1;

  // Status register field positions
  localparam int unsigned ST_CORE_RST    = 0;
  localparam int unsigned ST_PIN_LOW     = 1;
  localparam int unsigned ST_BROWNOUT    = 2;
  localparam int unsigned ST_MISMATCH    = 3;
  localparam int unsigned ST_POWER_UP_TIMER_RUN    = 4;
  localparam int unsigned ST_POWER_UP_TIMER_LSB    = 16;

  // Power-up timer states
  typedef enum logic [1:0] {
    RSPT_PT_HOLD,
    RSPT_PT_COUNT,
    RSPT_PT_DONE
  } rspt_pt_state_t;

  // One configuration word and its complementary shadow
  typedef struct packed {
    logic [CFG_WIDTH-1:0] value;
    logic [CFG_WIDTH-1:0] shadow;
  } rspt_cfg_pair_t;

  // Supply monitor inputs
  typedef struct packed {
    logic regulator_enable_pin;
    logic regulator_ok;
  } rspt_supply_t;

endpackage

// ==== hdl/rspt_pin_filter.sv ====
// Synchroniser and consecutive-sample glitch filter for the external reset pin
`timescale 1ns/1ps
module rspt_pin_filter (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Pin and filter length
  input  wire logic                          pin_in,
  input  wire logic [rspt_pkg::FILT_BITS-1:0] filt_len,
  // Qualified low level
  output logic                               pin_low
);

  logic                          sync1_q;
  logic                          sync2_q;
  logic [rspt_pkg::FILT_BITS-1:0] cnt_q;
  logic [rspt_pkg::FILT_BITS-1:0] cnt_d;
  logic                          pin_low_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Saturating count of consecutive low samples
  always_comb begin
    cnt_d = cnt_q;
    if (sync2_q) begin
      cnt_d = '0;
    end else if (cnt_q != '1) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Low only once enough samples agree; a high sample releases at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= !sync2_q && (cnt_d >= filt_len);
    end
  end

  assign pin_low = pin_low_q;

endmodule

// ==== test/rspt_supervisor_model.sv ====
// Behavioural external reset supervisor and supply feeding the reset block
`timescale 1ns/1ps
module rspt_supervisor_model (
  // Commands from the bench
  input  wire logic             press,
  input  wire logic             reg_on,
  input  wire logic             sag,
  // Pin level and supply state
  output logic                  pin,
  output rspt_pkg::rspt_supply_t supply
);
  // Pull-up wins whenever the supervisor lets go, so the idle level is high
  assign pin = !press;
  // Regulator enable strap and output health follow the bench commands
  assign supply = '{regulator_enable_pin: reg_on, regulator_ok: !sag};
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the reset source combiner and power-up timer
`timescale 1ns/1ps
module testbench;
  localparam int unsigned TICKS = 4;
  localparam int unsigned STEPS = 8;
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   hsel = 1'b0;
  logic [31:0]            haddr = 32'h0;
  logic [1:0]             htrans = 2'h0;
  logic                   hwrite = 1'b0;
  logic [31:0]            hwdata = 32'h0;
  logic [2:0]             hsize = 3'h0;
  logic [31:0]            hrdata;
  logic                   hreadyout;
  logic                   hresp;
  logic                   pin;
  logic                   pin_oe;
  logic                   pin_out;
  logic                   core_reset_n;
  logic                   press = 1'b0;
  logic                   reg_on = 1'b0;
  logic                   sag = 1'b0;
  logic [31:0]            rd;
  int                     miscompares = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  rspt_pkg::rspt_supply_t supply;
  rspt_pkg::rspt_cfg_pair_t [rspt_pkg::CFG_REGS-1:0] cfg;

  // Clock at 40 MHz
  always #12.5 hclk = ~hclk;

  rspt_supervisor_model u_sup (.press(press), .reg_on(reg_on), .sag(sag), .pin(pin), .supply(supply));

  // Short timer parameters keep each power-up interval at 32 cycles
  rspt_top #(.TICK_CYCLES(TICKS), .POWER_UP_TIMER_TICKS(STEPS)) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_reset_pin_in(pin), .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
    .supply(supply), .config_pairs(cfg), .core_reset_n(core_reset_n));

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; the wait ends only on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Core reset must reach v within hi cycles but not before lo
  task automatic wait_core(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (core_reset_n !== v && n < hi) begin
      @(negedge hclk);
      n++;
    end
    chk({31'h0, core_reset_n}, {31'h0, v});
    chk({31'h0, n >= lo}, 32'h1);
  endtask

  // Core reset holds v for n cycles and the pin is never driven meanwhile
  task automatic stays(input logic v, input int n);
    repeat (n) begin
      @(negedge hclk);
      chk({31'h0, core_reset_n}, {31'h0, v});
      chk({31'h0, pin_oe}, 32'h0);
      chk({31'h0, pin_out}, 32'h1);
    end
  endtask

  task automatic t_power_on();
    wait_core(1'b1, 28, 40);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'h3c);
    rdchk(rspt_pkg::OFS_CONTROL, 32'h4);
    rdchk(8'h0c, 32'h0);
    bus(1'b1, rspt_pkg::OFS_RESET_CTRL, 32'hb3);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'hbf);
    $display("done power_on");
  endtask

  task automatic t_pin();
    @(posedge hclk);
    press <= 1'b1;
    repeat (3) @(posedge hclk);
    press <= 1'b0;
    stays(1'b1, 12);
    @(posedge hclk);
    press <= 1'b1;
    wait_core(1'b0, 4, 10);
    stays(1'b0, 40);
    @(posedge hclk);
    press <= 1'b0;
    wait_core(1'b1, 1, 6);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'hbf);
    // A shorter filter lets the same three-cycle pulse through
    bus(1'b1, rspt_pkg::OFS_CONTROL, 32'h2);
    rdchk(rspt_pkg::OFS_CONTROL, 32'h2);
    @(posedge hclk);
    press <= 1'b1;
    repeat (3) @(posedge hclk);
    press <= 1'b0;
    wait_core(1'b0, 0, 4);
    wait_core(1'b1, 0, 4);
    bus(1'b1, rspt_pkg::OFS_CONTROL, 32'h4);
    rdchk(rspt_pkg::OFS_CONTROL, 32'h4);
    $display("done pin");
  endtask

  task automatic t_brownout();
    @(posedge hclk);
    reg_on <= 1'b1;
    sag <= 1'b1;
    wait_core(1'b0, 0, 3);
    rdchk(rspt_pkg::OFS_STATUS, 32'h5);
    @(posedge hclk);
    sag <= 1'b0;
    stays(1'b0, 12);
    @(posedge hclk);
    sag <= 1'b1;
    stays(1'b0, 4);
    @(posedge hclk);
    sag <= 1'b0;
    wait_core(1'b1, 28, 40);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'hbe);
    @(posedge hclk);
    reg_on <= 1'b0;
    sag <= 1'b1;
    bus(1'b1, rspt_pkg::OFS_RESET_CTRL, 32'hb3);
    stays(1'b1, 10);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'hbf);
    @(posedge hclk);
    sag <= 1'b0;
    $display("done brownout");
  endtask

  task automatic t_mismatch();
    @(posedge hclk);
    cfg[2].shadow <= 8'hf1;
    wait_core(1'b0, 0, 3);
    stays(1'b0, 5);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'h9f);
    @(posedge hclk);
    cfg[2].shadow <= 8'hf0;
    wait_core(1'b1, 0, 4);
    $display("done mismatch");
  endtask

  task automatic t_second_power_on();
    @(posedge hclk);
    hresetn <= 1'b0;
    stays(1'b0, 6);
    @(posedge hclk);
    hresetn <= 1'b1;
    wait_core(1'b1, 28, 40);
    rdchk(rspt_pkg::OFS_RESET_CTRL, 32'h3c);
    $display("done second_power_on");
  endtask

  // Healthy pairs hold each word beside its complement
  initial begin
    for (int i = 0; i < rspt_pkg::CFG_REGS; i++) begin
      cfg[i] = '{value: 8'h0f, shadow: 8'hf0};
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_power_on();
    t_pin();
    t_brownout();
    t_mismatch();
    t_second_power_on();
    summarize();
  end
endmodule
